// File: temp_sensor_pkg.sv
// Constants shared by the temperature sensor conversion and register logic.
// Assumes a 100 MHz reference clock; long counts are overridable by module parameters.
package temp_sensor_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ       = 100;
  localparam int CONV_TIME_US  = 27000;   // Typical conversion time.
  localparam int IDLE1_TIME_US = 28500;   // Rate 1: 18 Hz period less one conversion.
  localparam int IDLE2_TIME_US = 84000;   // Rate 2: 9 Hz period less one conversion.
  localparam int IDLE3_TIME_US = 223000;  // Rate 3: 4 Hz period less one conversion.
  localparam int CONV_CYCLES   = CONV_TIME_US * CLK_MHZ;
  localparam int IDLE1_CYCLES  = IDLE1_TIME_US * CLK_MHZ;
  localparam int IDLE2_CYCLES  = IDLE2_TIME_US * CLK_MHZ;
  localparam int IDLE3_CYCLES  = IDLE3_TIME_US * CLK_MHZ;

  // ****************************************************************
  // Register select codes, reset values and field positions
  // ****************************************************************
  localparam logic [1:0]  SEL_TEMP      = 2'h0;
  localparam logic [1:0]  SEL_CFG       = 2'h1;
  localparam logic [1:0]  SEL_LOWER     = 2'h2;
  localparam logic [1:0]  SEL_UPPER     = 2'h3;
  localparam logic [7:0]  SELECT_RESET  = 8'h00;
  localparam logic [15:0] TEMP_RESET    = 16'h0000;
  localparam logic [15:0] CFG_RESET     = 16'h00FF;
  localparam logic [15:0] LOWER_RESET   = 16'h4B00;
  localparam logic [15:0] UPPER_RESET   = 16'h5000;
  localparam logic [7:0]  CFG_LOW_BYTE  = 8'hFF;
  localparam int          VALUE_LSB     = 4;
  localparam int          CFG_OS_BIT    = 15;
  localparam int          CFG_RATE_LSB  = 13;
  localparam int          CFG_FQ_LSB    = 11;
  localparam int          CFG_POL_BIT   = 10;
  localparam int          CFG_TM_BIT    = 9;
  localparam int          CFG_SD_BIT    = 8;
  localparam logic [7:0]  GC_ADDR       = 8'h00;
  localparam logic [7:0]  GC_RESET_BYTE = 8'h06;

  typedef enum logic [1:0] {CONV, IDLE, SHUT} conv_state_t;
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ADDR_ACK, S_WRITE, S_WRITE_ACK, S_READ, S_READ_ACK} bus_state_t;

endpackage

// File: temp_sensor_core.sv
// Conversion sequencer, pointer-addressed register file, two-wire slave and alert logic.
// Assumes the result input is a same-clock signed 12-bit sample; bus pins are asynchronous.
// Functional notes
// - Convert repeatedly by default; each result overwrites the previous one.
// - Rate field selects 37, 18, 9 or 4 Hz; reset value zero.
// - Conversion takes 27 ms; slower rates idle the selected delay afterwards.
// - At rate zero a new conversion starts right after the previous.
// - After reset or general-call reset a conversion starts at once.
// - Shutdown request finishes the running conversion, then stops converting.
// - Shutdown request zero, its reset value, means continuous conversion.
// - Rising shutdown clears alert and fault counter; rewriting one does not.
// - While shut down, one-shot write runs exactly one conversion, then returns.
// - Configuration reads always show zero in the one-shot bit.
// - Master writes a select byte; its two low bits pick the register.
// - Select register is write-only and resets to temperature.
// - Result is 12 bits in 15..4; low nibble reads zero.
// - Configuration resets to 00FFh; low byte is read-only FFh.
// - Fault depth field needs 1, 2, 4 or 6 consecutive faults.
// - Level-sense bit sets alert polarity: zero active low, one active high.
// - Trip-style bit: zero comparator behaviour, one interrupt behaviour.
// - Lower limit is 12 bits in 15..4, reset 4B00h, low nibble zero.
// - Upper limit is 12 bits in 15..4, reset 5000h, low nibble zero.
`timescale 1ns/1ps
module temp_sensor_core
  import temp_sensor_pkg::*;
#(
  parameter int         CONV_CYC    = CONV_CYCLES,
  parameter int         IDLE1_CYC   = IDLE1_CYCLES,
  parameter int         IDLE2_CYC   = IDLE2_CYCLES,
  parameter int         IDLE3_CYC   = IDLE3_CYCLES,
  parameter int         CNT_W       = 25,
  parameter logic [3:0] BUS_ADDR_HI = 4'h9
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output wire logic        o_sda_o,
  output wire logic        o_sda_oe,
  input  wire logic [2:0]  i_addr_pins,
  input  wire logic [11:0] i_adc_sample,
  output wire logic        o_conv_active,
  output wire logic        o_alert_o,
  output wire logic        o_alert_oe
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
    logic [2:0]       adr_m;
    logic [2:0]       adr_s;
    bus_state_t       bst;
    logic [3:0]       bcnt;
    logic [7:0]       sh;
    logic [1:0]       bidx;
    logic             rw;
    logic             gc;
    logic [15:0]      tx;
    logic             sda_oe;
    logic [7:0]       sel;
    conv_state_t      cst;
    logic [CNT_W-1:0] tmr;
    logic             os_pend;
    logic [1:0]       rate;
    logic [1:0]       fq;
    logic             alarm_level_sense, tm, sd;
    logic [11:0]      temp, lo, hi;
    logic [2:0]       faults;
    logic             alert;
    logic             arm_hi;
  } state_t;

  localparam state_t ST_RESET = '{scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1,
    sda_p: 1'b1, adr_m: 3'h0, adr_s: 3'h0, bst: S_IDLE, bcnt: 4'h0, sh: 8'h00, bidx: 2'h0, rw: 1'b0,
    gc: 1'b0, tx: 16'h0000, sda_oe: 1'b0, sel: SELECT_RESET, cst: CONV, tmr: CNT_W'(CONV_CYC - 1),
    os_pend: 1'b0, rate: CFG_RESET[CFG_RATE_LSB +: 2], fq: CFG_RESET[CFG_FQ_LSB +: 2],
    alarm_level_sense: CFG_RESET[CFG_POL_BIT], tm: CFG_RESET[CFG_TM_BIT], sd: CFG_RESET[CFG_SD_BIT],
    temp: TEMP_RESET[15:VALUE_LSB], lo: LOWER_RESET[15:VALUE_LSB], hi: UPPER_RESET[15:VALUE_LSB],
    faults: 3'h0, alert: 1'b0, arm_hi: 1'b1};

  state_t r, n;

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  // Read view of a register; reserved bits and the one-shot bit are forced here.
  function automatic logic [15:0] reg_read(input logic [1:0] s_idx, input state_t s);
    logic [15:0] v;
    v = 16'h0000;
    unique case (s_idx)
      SEL_TEMP:  v = {s.temp, 4'h0};
      SEL_CFG:   v = {1'b0, s.rate, s.fq, s.alarm_level_sense, s.tm, s.sd, CFG_LOW_BYTE};
      SEL_LOWER: v = {s.lo, 4'h0};
      SEL_UPPER: v = {s.hi, 4'h0};
    endcase
    return v;
  endfunction

  function automatic logic [2:0] fault_depth(input logic [1:0] q);
    logic [2:0] d;
    d = 3'h1;
    unique case (q)
      2'h0: d = 3'h1;
      2'h1: d = 3'h2;
      2'h2: d = 3'h4;
      2'h3: d = 3'h6;
    endcase
    return d;
  endfunction

  function automatic logic [CNT_W-1:0] idle_load(input logic [1:0] q);
    logic [CNT_W-1:0] c;
    c = CNT_W'(IDLE1_CYC - 1);
    unique case (q)
      2'h0: c = CNT_W'(CONV_CYC - 1);
      2'h1: c = CNT_W'(IDLE1_CYC - 1);
      2'h2: c = CNT_W'(IDLE2_CYC - 1);
      2'h3: c = CNT_W'(IDLE3_CYC - 1);
    endcase
    return c;
  endfunction

  // Bus line events, taken from the second and third sampling stages only.
  wire logic scl_rise = r.scl_s & ~r.scl_p;
  wire logic scl_fall = ~r.scl_s & r.scl_p;
  wire logic bus_start = r.scl_s & r.scl_p & r.sda_p & ~r.sda_s;
  wire logic bus_stop = r.scl_s & r.scl_p & ~r.sda_p & r.sda_s;
  wire logic conv_end = (r.cst == CONV) && (r.tmr == '0);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // One process builds the whole next state; later assignments take priority.
  always_comb begin
    logic [15:0] rv;
    logic        gc_rst;
    logic        trip;
    logic [2:0]  nf;
    rv = reg_read(r.sel[1:0], r);
    gc_rst = 1'b0;
    trip = 1'b0;
    nf = r.faults + 3'h1;
    n = r;
    n.scl_m = i_scl;
    n.scl_s = r.scl_m;
    n.scl_p = r.scl_s;
    n.sda_m = i_sda;
    n.sda_s = r.sda_m;
    n.sda_p = r.sda_s;
    n.adr_m = i_addr_pins;
    n.adr_s = r.adr_m;

    // Two-wire slave; SDA only changes after SCL falls.
    unique case (r.bst)
      S_IDLE: ;
      S_ADDR: begin
        if (scl_rise) begin
          n.sh = {r.sh[6:0], r.sda_s};
          n.bcnt = r.bcnt + 4'h1;
        end else if (scl_fall && r.bcnt == 4'h8) begin
          if (r.sh[7:1] == {BUS_ADDR_HI, r.adr_s} || r.sh == GC_ADDR) begin
            n.sda_oe = 1'b1;
            n.rw = r.sh[0];
            n.gc = (r.sh == GC_ADDR);
            n.bst = S_ADDR_ACK;
          end else begin
            n.bst = S_IDLE;
          end
        end
      end
      S_ADDR_ACK: begin
        if (scl_fall) begin
          n.bcnt = 4'h0;
          if (r.rw) begin
            n.tx = rv;
            n.sda_oe = ~rv[15];
            n.bst = S_READ;
            if (r.tm) begin
              n.alert = 1'b0;
            end
          end else begin
            n.sda_oe = 1'b0;
            n.bst = S_WRITE;
          end
        end
      end
      S_WRITE: begin
        if (scl_rise) begin
          n.sh = {r.sh[6:0], r.sda_s};
          n.bcnt = r.bcnt + 4'h1;
        end else if (scl_fall && r.bcnt == 4'h8) begin
          n.sda_oe = 1'b1;
          n.bst = S_WRITE_ACK;
          if (r.bidx != 2'h3) begin
            n.bidx = r.bidx + 2'h1;
          end
          if (r.gc) begin
            gc_rst = (r.sh == GC_RESET_BYTE) && (r.bidx == 2'h0);
          end else if (r.bidx == 2'h0) begin
            n.sel = r.sh;
          end else if (r.bidx == 2'h1) begin
            // Upper byte; the result register ignores writes.
            unique case (r.sel[1:0])
              SEL_TEMP: ;
              SEL_CFG: begin
                n.rate = r.sh[CFG_RATE_LSB-8 +: 2];
                n.fq = r.sh[CFG_FQ_LSB-8 +: 2];
                n.alarm_level_sense = r.sh[CFG_POL_BIT-8];
                n.tm = r.sh[CFG_TM_BIT-8];
                n.sd = r.sh[CFG_SD_BIT-8];
                if (r.sh[CFG_OS_BIT-8] && r.sd) begin
                  n.os_pend = 1'b1;
                end
                if (r.sh[CFG_SD_BIT-8] && !r.sd) begin
                  n.faults = 3'h0;
                  n.alert = 1'b0;
                  n.arm_hi = 1'b1;
                end
              end
              SEL_LOWER: n.lo[11:4] = r.sh;
              SEL_UPPER: n.hi[11:4] = r.sh;
            endcase
          end else if (r.bidx == 2'h2) begin
            // Lower byte: only the limit nibbles are writable.
            if (r.sel[1:0] == SEL_LOWER) begin
              n.lo[3:0] = r.sh[7:4];
            end
            if (r.sel[1:0] == SEL_UPPER) begin
              n.hi[3:0] = r.sh[7:4];
            end
          end
        end
      end
      S_WRITE_ACK: begin
        if (scl_fall) begin
          n.sda_oe = 1'b0;
          n.bcnt = 4'h0;
          n.bst = S_WRITE;
        end
      end
      S_READ: begin
        if (scl_rise) begin
          n.bcnt = r.bcnt + 4'h1;
        end else if (scl_fall) begin
          n.tx = {r.tx[14:0], 1'b0};
          if (r.bcnt == 4'h8) begin
            n.sda_oe = 1'b0;
            n.bst = S_READ_ACK;
          end else begin
            n.sda_oe = ~r.tx[14];
          end
        end
      end
      S_READ_ACK: begin
        if (scl_rise && r.sda_s) begin
          n.bst = S_IDLE; // Master declined further bytes.
        end else if (scl_fall) begin
          n.bcnt = 4'h0;
          n.bidx[0] = ~r.bidx[0];
          n.tx = r.bidx[0] ? rv : r.tx;
          n.sda_oe = r.bidx[0] ? ~rv[15] : ~r.tx[15];
          n.bst = S_READ;
        end
      end
    endcase
    if (bus_start) begin
      n.bst = S_ADDR;
      n.bcnt = 4'h0;
      n.bidx = 2'h0;
      n.sda_oe = 1'b0;
    end else if (bus_stop) begin
      n.bst = S_IDLE;
      n.sda_oe = 1'b0;
    end

    // Conversion sequencer; a finished conversion wins over any clear above.
    unique case (r.cst)
      CONV: begin
        if (!conv_end) begin
          n.tmr = r.tmr - CNT_W'(1);
        end else begin
          n.temp = i_adc_sample;
          if (r.tm) begin
            trip = r.arm_hi ? ($signed(i_adc_sample) >= $signed(r.hi)) : ($signed(i_adc_sample) < $signed(r.lo));
          end else begin
            trip = r.alert ? ($signed(i_adc_sample) < $signed(r.lo)) : ($signed(i_adc_sample) >= $signed(r.hi));
          end
          n.faults = 3'h0;
          if (trip && nf >= fault_depth(r.fq)) begin
            n.alert = r.tm ? 1'b1 : ~r.alert;
            n.arm_hi = r.tm ? ~r.arm_hi : r.arm_hi;
          end else if (trip) begin
            n.faults = nf;
          end
          if (r.sd) begin
            n.cst = SHUT;
          end else if (r.rate == 2'h0) begin
            n.tmr = CNT_W'(CONV_CYC - 1);
          end else begin
            n.cst = IDLE;
            n.tmr = idle_load(r.rate);
          end
        end
      end
      IDLE: begin
        if (r.sd) begin
          n.cst = SHUT;
        end else if (r.tmr == '0) begin
          n.cst = CONV;
          n.tmr = CNT_W'(CONV_CYC - 1);
        end else begin
          n.tmr = r.tmr - CNT_W'(1);
        end
      end
      SHUT: begin
        if (r.os_pend || !r.sd) begin
          n.cst = CONV;
          n.os_pend = 1'b0;
          n.tmr = CNT_W'(CONV_CYC - 1);
        end
      end
    endcase

    // General-call reset restores registers and restarts conversion at once.
    if (gc_rst) begin
      n.sel = ST_RESET.sel;
      n.rate = ST_RESET.rate;
      n.fq = ST_RESET.fq;
      n.alarm_level_sense = ST_RESET.alarm_level_sense;
      n.tm = ST_RESET.tm;
      n.sd = ST_RESET.sd;
      n.lo = ST_RESET.lo;
      n.hi = ST_RESET.hi;
      n.faults = 3'h0;
      n.alert = 1'b0;
      n.arm_hi = 1'b1;
      n.os_pend = 1'b0;
      n.cst = CONV;
      n.tmr = ST_RESET.tmr;
    end
  end

  // State register; reset starts the first conversion immediately.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= ST_RESET;
    end else begin
      r <= n;
    end
  end

  // Open-drain drivers only ever pull low.
  assign o_sda_o = 1'b0;
  assign o_sda_oe = r.sda_oe;
  assign o_alert_o = 1'b0;
  assign o_alert_oe = r.alert ^ r.alarm_level_sense;
  assign o_conv_active = (r.cst == CONV);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  sequence conv_finishing;
    r.cst == CONV && r.tmr == '0;
  endsequence

  sequence own_addr_seen;
    r.bst == S_ADDR && scl_fall && r.bcnt == 4'h8 && r.sh[7:1] == {BUS_ADDR_HI, r.adr_s};
  endsequence

  AST_RESULT_STORED: assert property (conv_finishing |=> r.temp == $past(i_adc_sample))
    else $error("Result not stored at conversion end.");
  AST_BACK_TO_BACK: assert property ((conv_finishing and (!r.sd && r.rate == 2'h0))
    |=> r.cst == CONV && r.tmr == CNT_W'(CONV_CYC - 1))
    else $error("Default rate did not restart conversion.");
  AST_RATE_DELAY: assert property ((conv_finishing and (!r.sd && r.rate != 2'h0))
    |=> r.cst == IDLE && r.tmr == idle_load($past(r.rate)))
    else $error("Rate delay not loaded.");
  AST_FINISH_THEN_SHUT: assert property ((r.cst == CONV && r.tmr != '0 && r.sd) |=> r.cst == CONV)
    else $error("Conversion abandoned on shutdown.");
  AST_SHUT_AFTER_CONV: assert property ((conv_finishing and r.sd) |=> r.cst == SHUT ##1 r.cst != IDLE)
    else $error("No shutdown after final conversion.");
  AST_RESUME: assert property ((r.cst == SHUT && !r.sd) |=> r.cst == CONV)
    else $error("Continuous mode not resumed.");
  AST_ONE_SHOT: assert property ((r.cst == SHUT && r.os_pend) |=> r.cst == CONV && !r.os_pend)
    else $error("One-shot did not start.");
  AST_SD_CLEAR: assert property (($rose(r.sd) && $past(r.cst) != CONV) |-> r.faults == 3'h0 && !r.alert)
    else $error("Shutdown edge did not clear alert.");
  AST_OS_READS_ZERO: assert property ((r.bst == S_ADDR_ACK && scl_fall && r.rw && r.sel[1:0] == SEL_CFG)
    |=> r.tx[15] == 1'b0 && r.sda_oe)
    else $error("One-shot bit read as one.");
  AST_FAULT_BOUND: assert property (conv_finishing |=> r.faults < fault_depth($past(r.fq)))
    else $error("Fault count reached depth without trip.");
  AST_ALERT_CAUSE: assert property ($rose(r.alert) |-> $past(r.cst == CONV && r.tmr == '0))
    else $error("Alert set outside conversion end.");
  AST_ADDR_ACK: assert property (own_addr_seen |=> r.bst == S_ADDR_ACK && r.sda_oe)
    else $error("Own address not acknowledged.");

endmodule

// File: two_wire_master.sv
// Behavioural two-wire bus master that stands in for the host controller.
// Assumes an open-drain data line with a pull-up, resolved by the bench.
`timescale 1ns/1ps
module two_wire_master #(
  parameter realtime HALF = 62.5
) (
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_oe
);
  // ****************
  // Bit and byte level
  // ****************
  // The clock idles high between frames and data only moves while it is low.
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end

  task automatic put_bit(input logic b);
    o_sda_oe = ~b;
    #(HALF / 2);
    o_scl = 1'b1;
    #(HALF);
    o_scl = 1'b0;
    #(HALF / 2);
  endtask

  // Releasing the line lets the pull-up win unless the device holds it low.
  task automatic get_bit(output logic b);
    o_sda_oe = 1'b0;
    #(HALF / 2);
    o_scl = 1'b1;
    #(HALF / 2);
    b = i_sda;
    #(HALF / 2);
    o_scl = 1'b0;
    #(HALF / 2);
  endtask

  task automatic put_byte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i]);
    end
    get_bit(ack);
  endtask

  task automatic get_byte(input logic ack, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      get_bit(v[i]);
    end
    put_bit(ack);
  endtask

  // ****************
  // Frames
  // ****************
  // Start pulls data low under a high clock; stop releases it likewise.
  task automatic start_frame();
    o_sda_oe = 1'b1;
    #(HALF / 2);
    o_scl = 1'b0;
    #(HALF / 2);
  endtask

  task automatic stop_frame();
    o_sda_oe = 1'b1;
    #(HALF / 2);
    o_scl = 1'b1;
    #(HALF / 2);
    o_sda_oe = 1'b0;
    #(HALF);
  endtask

  // Write: address, select byte, then nb data bytes, most significant first.
  task automatic wr_frame(input logic [6:0] adr, input logic [7:0] sel, input logic [15:0] v,
                          input int nb, output logic ack);
    logic a;
    start_frame();
    put_byte({adr, 1'b0}, ack);
    put_byte(sel, a);
    if (nb > 0) begin
      put_byte(v[15:8], a);
    end
    if (nb > 1) begin
      put_byte(v[7:0], a);
    end
    stop_frame();
  endtask

  // Read: acknowledge the first byte, refuse the second to end the transfer.
  task automatic rd_frame(input logic [6:0] adr, output logic [15:0] v, output logic ack);
    start_frame();
    put_byte({adr, 1'b1}, ack);
    get_byte(1'b0, v[15:8]);
    get_byte(1'b1, v[7:0]);
    stop_frame();
  endtask
endmodule

// File: tb.sv
// Self-checking bench for the sensor core: registers, rates, shutdown, one-shot, alert.
// Assumes the two-wire master model and shortened conversion and idle counts.
`timescale 1ns/1ps
module tb;
  import temp_sensor_pkg::*;
  localparam int CONV = 1000;
  localparam int IDL [4] = '{0, 500, 1500, 2500};
  logic        clk;
  logic        rstn;
  logic [2:0]  pins;
  logic [11:0] sample;
  logic        dut_oe;
  logic        m_scl;
  logic        m_oe;
  logic        conv;
  logic        alert_oe;
  wire         sda = ~(dut_oe | m_oe);
  int          seed;
  int          n_mismatch;
  int          total_checks;
  logic [15:0] exp_q[$];
  string       nm_q[$];
  logic [15:0] obs_val;
  event        obs_ev;
  logic [6:0]  adr;
  logic [15:0] d;
  logic        ack;
  int          n;

  // ****************
  // Clock and instances
  // ****************
  always #5 clk = ~clk;

  temp_sensor_core #(.CONV_CYC(CONV), .IDLE1_CYC(IDL[1]), .IDLE2_CYC(IDL[2]), .IDLE3_CYC(IDL[3]),
                     .CNT_W(25), .BUS_ADDR_HI(4'h9)) dut_u (
    .i_ref_clk(clk), .i_rstn(rstn), .i_scl(m_scl), .i_sda(sda), .o_sda_o(), .o_sda_oe(dut_oe),
    .i_addr_pins(pins), .i_adc_sample(sample), .o_conv_active(conv), .o_alert_o(),
    .o_alert_oe(alert_oe));

  two_wire_master m_u (.i_sda(sda), .o_scl(m_scl), .o_sda_oe(m_oe));

  // ****************
  // Checking
  // ****************
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // The driver notes what it expects; the watcher pairs it with what appeared.
  task automatic observe(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    nm_q.push_back(nm);
    exp_q.push_back(exp);
    obs_val = seen;
    -> obs_ev;
    #1;
  endtask

  always @(obs_ev) begin
    chk(nm_q.pop_front(), obs_val, exp_q.pop_front());
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************
  // Helpers
  // ****************
  task automatic cycles(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [1:0] sel, input logic [15:0] v, input int nb);
    m_u.wr_frame(adr, {6'h00, sel}, v, nb, ack);
  endtask

  // A read first points the select register, then fetches both bytes.
  task automatic expect_reg(input string nm, input logic [1:0] sel, input logic [15:0] exp);
    logic [15:0] v;
    m_u.wr_frame(adr, {6'h00, sel}, 16'h0000, 0, ack);
    m_u.rd_frame(adr, v, ack);
    observe(nm, exp, v);
  endtask

  // Bounded waits so a stuck sequencer ends in a mismatch, not a hang.
  task automatic wait_conv(input logic lvl);
    int k;
    k = 0;
    while (conv !== lvl && k < 4000) begin
      @(posedge clk);
      k++;
    end
  endtask

  task automatic run_len(input logic lvl, output int len);
    len = 0;
    while (conv === lvl && len < 3000) begin
      @(posedge clk);
      len++;
    end
  endtask

  // Hang guard sized well above the expected run length.
  initial begin
    cycles(90000);
    n_mismatch++;
    give_verdict();
  end

  // ****************
  // Test sequence
  // ****************
  initial begin
    seed = 32'hAE852C7A;
    clk = 1'b0;
    rstn = 1'b0;
    pins = 3'h0;
    sample = 12'h000;
    n_mismatch = 0;
    total_checks = 0;
    @(posedge clk);
    pins <= 3'($random(seed));
    sample <= 12'($random(seed));
    cycles(4);
    rstn <= 1'b1;
    cycles(4);
    adr = {4'h9, pins};
    m_u.rd_frame(adr, d, ack);
    observe("temp before first result", 16'h0000, d);
    expect_reg("cfg reset", SEL_CFG, 16'h00FF);
    expect_reg("lower reset", SEL_LOWER, 16'h4B00);
    expect_reg("upper reset", SEL_UPPER, 16'h5000);
    expect_reg("first result", SEL_TEMP, {sample, 4'h0});
    m_u.rd_frame(adr ^ 7'h01, d, ack);
    observe("foreign address", 16'h0001, {15'h0000, ack});
    // Each new random sample must replace the previous result.
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) sample <= 12'($random(seed));
      cycles(CONV + 10);
      expect_reg("new result", SEL_TEMP, {sample, 4'h0});
    end
    wr_reg(SEL_LOWER, 16'h0F0F, 2);
    expect_reg("lower write", SEL_LOWER, 16'h0F00);
    wr_reg(SEL_UPPER, 16'h1405, 2);
    expect_reg("upper write", SEL_UPPER, 16'h1400);
    wr_reg(SEL_TEMP, 16'hFFFF, 2);
    expect_reg("result write", SEL_TEMP, {sample, 4'h0});
    wr_reg(SEL_CFG, 16'h0000, 2);
    expect_reg("cfg low byte", SEL_CFG, 16'h00FF);
    // Rate zero never drops the flag; slower rates idle for their delay.
    run_len(1'b1, n);
    observe("rate zero gap", 16'h0001, {15'h0000, n == 3000});
    for (int r = 1; r < 4; r++) begin
      wr_reg(SEL_CFG, {1'b0, 2'(r), 13'h0000}, 1);
      wait_conv(1'b0);
      wait_conv(1'b1);
      wait_conv(1'b0);
      run_len(1'b0, n);
      observe("idle length", 16'h0001, {15'h0000, n >= IDL[r] - 1 && n <= IDL[r] + 1});
      run_len(1'b1, n);
      observe("conversion length", 16'h0001, {15'h0000, n >= CONV - 2 && n <= CONV + 2});
    end
    // Shutdown clears the queue, then depth d needs 1, 2, 4 or 6 hot results.
    for (int q = 0; q < 4; q++) begin
      @(posedge clk) sample <= 12'h120;
      wr_reg(SEL_CFG, 16'h0100, 1);
      wr_reg(SEL_CFG, {3'b001, 2'(q), 11'h000}, 1);
      wait_conv(1'b0);
      @(posedge clk) sample <= 12'h200;
      n = 0;
      while (alert_oe !== 1'b1 && n < 8) begin
        wait_conv(1'b1);
        wait_conv(1'b0);
        cycles(5);
        n++;
      end
      observe("fault depth", 16'(q == 0 ? 1 : q * 2), 16'(n));
    end
    @(posedge clk) sample <= 12'h120;
    wr_reg(SEL_CFG, 16'h0100, 1);
    observe("alert on shutdown", 16'h0000, {15'h0000, alert_oe});
    wait_conv(1'b0);
    run_len(1'b0, n);
    observe("stays shut", 16'h0001, {15'h0000, n == 3000});
    observe("alert after last", 16'h0000, {15'h0000, alert_oe});
    // One-shot from shutdown runs a single hot conversion.
    @(posedge clk) sample <= 12'h200;
    wr_reg(SEL_CFG, 16'h8100, 1);
    wait_conv(1'b1);
    run_len(1'b1, n);
    observe("one conversion", 16'h0001, {15'h0000, n >= CONV - 50 && n <= CONV + 2});
    run_len(1'b0, n);
    observe("back to shutdown", 16'h0001, {15'h0000, n == 3000});
    observe("alert one shot", 16'h0001, {15'h0000, alert_oe});
    expect_reg("cfg one shot", SEL_CFG, 16'h01FF);
    wr_reg(SEL_CFG, 16'h0100, 1);
    observe("alert kept", 16'h0001, {15'h0000, alert_oe});
    wr_reg(SEL_CFG, 16'h0500, 1);
    observe("alert polarity", 16'h0000, {15'h0000, alert_oe});
    // Comparator style releases once a result falls below the lower limit.
    @(posedge clk) sample <= 12'h080;
    wr_reg(SEL_CFG, 16'h2000, 1);
    wait_conv(1'b0);
    cycles(5);
    observe("alert released", 16'h0000, {15'h0000, alert_oe});
    // Interrupt style: a fresh one-shot trip sets the alert and a read clears it.
    @(posedge clk) sample <= 12'h200;
    wr_reg(SEL_CFG, 16'h0300, 1);
    wr_reg(SEL_CFG, 16'h8300, 1);
    wait_conv(1'b0);
    cycles(5);
    observe("alert tripped", 16'h0001, {15'h0000, alert_oe});
    expect_reg("cfg interrupt", SEL_CFG, 16'h03FF);
    observe("alert read clear", 16'h0000, {15'h0000, alert_oe});
    // General-call reset restores every register except the result and restarts conversion at once.
    m_u.wr_frame(7'h00, GC_RESET_BYTE, 16'h0000, 0, ack);
    observe("gc ack", 16'h0000, {15'h0000, ack});
    observe("gc converting", 16'h0001, {15'h0000, conv});
    m_u.rd_frame(adr, d, ack);
    observe("gc select reset", {12'h200, 4'h0}, d);
    expect_reg("gc cfg", SEL_CFG, 16'h00FF);
    expect_reg("gc upper", SEL_UPPER, 16'h5000);
    give_verdict();
  end
endmodule
